// *** logic/dpo_top.sv ***
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`include "dpo_defines.svh"

// Operation
// - output 32-bit word with clock from link
// - lock low means data and clock released
// - edge select high rising, low falling update
// - output enable low releases data and clock
// - standby low stops recovery, releases data, clock and lock outputs
// - take serial data on up to four lanes
module dpo_top
    import dpo_pkg::*;
(
    input  wire logic        clk,                // system clock, 50 MHz
    input  wire logic        rst,                // sync reset, active high
    input  wire logic        link_clk,           // embedded link clock pin
    input  wire logic [3:0]  serial_lane_in,     // serial lanes 0..3
    input  wire logic        standby_n,          // standby, active low
    input  wire logic        output_enable,      // output enable pin
    input  wire logic        output_edge_select, // 1 rising, 0 falling
    input  wire logic        reserved_strap,     // must be held low
    output logic [31:0]      recovered_data_out, // parallel word
    output logic             recovered_data_oe,  // data drive enable
    output logic             recovered_clock_out,// parallel rate clock
    output logic             recovered_clock_oe, // clock drive enable
    output logic             lock_out,           // lock status
    output logic             lock_oe,            // lock drive enable
    output logic             irq,                // level interrupt
    input  wire logic [4:0]  s_axi_awaddr,       // write address
    input  wire logic        s_axi_awvalid,      // write address valid
    output logic             s_axi_awready,      // write address ready
    input  wire logic [31:0] s_axi_wdata,        // write data
    input  wire logic [3:0]  s_axi_wstrb,        // write strobes
    input  wire logic        s_axi_wvalid,       // write data valid
    output logic             s_axi_wready,       // write data ready
    output logic [1:0]       s_axi_bresp,        // write response
    output logic             s_axi_bvalid,       // write response valid
    input  wire logic        s_axi_bready,       // write response ready
    input  wire logic [4:0]  s_axi_araddr,       // read address
    input  wire logic        s_axi_arvalid,      // read address valid
    output logic             s_axi_arready,      // read address ready
    output logic [31:0]      s_axi_rdata,        // read data
    output logic [1:0]       s_axi_rresp,        // read response
    output logic             s_axi_rvalid,       // read data valid
    input  wire logic        s_axi_rready        // read data ready
);

    dpo_state_t st_ff;    // registered state
    dpo_state_t nxt_st;   // next state
    logic       link_edge; // synced rising edge of link clock
    logic       awake;     // standby pin high
    logic       drive;     // data and clock may be driven
    logic [4:0] last_bit;  // final edge index of a word
    logic [4:0] half_bit;  // edge index where clock falls
    logic       word_done; // word completes this cycle
    logic       wr_fire;   // both write halves held
    logic [2:0] clr_bits;  // software clear of sticky events
    logic [2:0] set_bits;  // hardware events this cycle

    // decoded views of synced pins
    always_comb begin
        link_edge = st_ff.pin_s2[`DPO_PIN_LCLK] & ~st_ff.link_prev;
        awake     = st_ff.pin_s2[`DPO_PIN_STBY];
        drive     = awake & st_ff.pin_s2[`DPO_PIN_OE]
                  & (st_ff.lock == DPO_LOCKED);
        last_bit  = (st_ff.quad ? `DPO_BITS_QUAD : `DPO_BITS_DUAL) - 5'h01;
        half_bit  = {1'b0, last_bit[4:1]};
        word_done = awake & link_edge & (st_ff.bitcnt == last_bit);
        wr_fire   = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
    end

    // next-state logic
    always_comb begin
        nxt_st = st_ff;
        set_bits = 3'h0;
        clr_bits = 3'h0;
        // two-stage sync of every pin from outside the clock domain
        nxt_st.pin_s1 = {reserved_strap, output_edge_select, output_enable,
                         standby_n, serial_lane_in, link_clk};
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.link_prev = st_ff.pin_s2[`DPO_PIN_LCLK];

        if (!awake) begin
            // standby: recovery loop held off, lock dropped
            if (st_ff.lock == DPO_LOCKED)
                set_bits[`DPO_IRQ_UNLOCKED] = 1'b1;
            nxt_st.lock   = DPO_HUNT;
            nxt_st.bitcnt = 5'h00;
            nxt_st.words  = 3'h0;
            nxt_st.idle   = 8'h00;
            nxt_st.rclk   = 1'b0;
        end else if (link_edge) begin
            // one bit per active lane per link edge
            nxt_st.idle = 8'h00;
            if (st_ff.quad)
                nxt_st.shift = {st_ff.shift[27:0], serial_bits(st_ff)};
            else
                nxt_st.shift = {st_ff.shift[29:0], st_ff.pin_s2[2:1]};
            if (word_done) begin
                // word boundary: recovered clock rises
                nxt_st.bitcnt = 5'h00;
                nxt_st.hold   = nxt_st.shift;
                nxt_st.rclk   = 1'b1;
                set_bits[`DPO_IRQ_WORD] = 1'b1;
                case (st_ff.lock)
                    DPO_HUNT: begin
                        if (st_ff.words == `DPO_LOCK_WORDS - 3'h1) begin
                            nxt_st.lock = DPO_LOCKED;
                            set_bits[`DPO_IRQ_LOCKED] = 1'b1;
                        end else begin
                            nxt_st.words = st_ff.words + 3'h1;
                        end
                    end
                    DPO_LOCKED: begin
                        nxt_st.lock = DPO_LOCKED;
                    end
                    default: begin
                        nxt_st.lock = DPO_HUNT;
                    end
                endcase
            end else begin
                nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
                if (st_ff.bitcnt == half_bit)
                    nxt_st.rclk = 1'b0;
            end
        end else if (st_ff.idle == 8'(`DPO_LINK_IDLE_CYC)) begin
            // stream gone: fall back to hunting
            if (st_ff.lock == DPO_LOCKED)
                set_bits[`DPO_IRQ_UNLOCKED] = 1'b1;
            nxt_st.lock   = DPO_HUNT;
            nxt_st.words  = 3'h0;
            nxt_st.bitcnt = 5'h00;
            nxt_st.rclk   = 1'b0;
        end else begin
            nxt_st.idle = st_ff.idle + 8'h01;
        end

        // output word follows the chosen recovered clock edge
        if (st_ff.pin_s2[`DPO_PIN_EDGE] ? (nxt_st.rclk & ~st_ff.rclk)
                                        : (~nxt_st.rclk & st_ff.rclk))
            nxt_st.dout = st_ff.pin_s2[`DPO_PIN_EDGE] ? nxt_st.hold
                                                      : st_ff.hold;

        // axi write channel: halves taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = s_axi_wdata;
        end
        if (wr_fire) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = 2'b00;
            case ({st_ff.awaddr[4:2], 2'b00})
                `DPO_OFF_CTRL: begin
                    if (s_axi_wstrb_ok(st_ff))
                        nxt_st.quad = st_ff.wdata[`DPO_CTRL_QUAD];
                end
                `DPO_OFF_IRQ_EN: begin
                    if (s_axi_wstrb_ok(st_ff))
                        nxt_st.irq_en = st_ff.wdata[2:0];
                end
                `DPO_OFF_IRQ_CLR: begin
                    if (s_axi_wstrb_ok(st_ff))
                        clr_bits = st_ff.wdata[2:0];
                end
                `DPO_OFF_STATUS, `DPO_OFF_IRQ_STAT, `DPO_OFF_WORD: begin
                    nxt_st.bresp = 2'b00; // read-only, write ignored
                end
                default: begin
                    nxt_st.bresp = 2'b10; // unmapped
                end
            endcase
        end
        if (st_ff.bvalid && s_axi_bready)
            nxt_st.bvalid = 1'b0;

        // axi read channel: answer one cycle after address taken
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = 2'b00;
            case ({s_axi_araddr[4:2], 2'b00})
                `DPO_OFF_CTRL:     nxt_st.rdata = {31'h0, st_ff.quad};
                `DPO_OFF_STATUS:   nxt_st.rdata = {29'h0,
                                       st_ff.pin_s2[`DPO_PIN_STRAP], awake,
                                       st_ff.lock == DPO_LOCKED};
                `DPO_OFF_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.irq_stat};
                `DPO_OFF_IRQ_EN:   nxt_st.rdata = {29'h0, st_ff.irq_en};
                `DPO_OFF_IRQ_CLR:  nxt_st.rdata = 32'h0;
                `DPO_OFF_WORD:     nxt_st.rdata = st_ff.hold;
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = 2'b10;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // sticky events: a new event beats a same-cycle clear
        nxt_st.irq_stat = (st_ff.irq_stat & ~clr_bits) | set_bits;
    end

    // lanes 0..3 in one nibble, lane 3 as the high bit
    function automatic logic [3:0] serial_bits(input dpo_state_t s);
        serial_bits = s.pin_s2[4:1];
    endfunction

    // write strobes are not checked; any held write to a writable offset takes effect
    function automatic logic s_axi_wstrb_ok(input dpo_state_t s);
        s_axi_wstrb_ok = s.w_got;
    endfunction

    // state register; reset loads constants only
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff        <= '0;
            st_ff.lock   <= DPO_HUNT;
            st_ff.quad   <= `DPO_CTRL_RST;
            st_ff.irq_en <= `DPO_IRQ_EN_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // pins and bus outputs
    always_comb begin
        recovered_data_out  = st_ff.dout;
        recovered_data_oe   = drive;
        recovered_clock_out = st_ff.rclk;
        recovered_clock_oe  = drive;
        lock_out            = (st_ff.lock == DPO_LOCKED) & awake;
        lock_oe             = awake;
        irq                 = |(st_ff.irq_stat & st_ff.irq_en);
        s_axi_awready       = ~st_ff.aw_got & ~st_ff.bvalid;
        s_axi_wready        = ~st_ff.w_got & ~st_ff.bvalid;
        s_axi_bvalid        = st_ff.bvalid;
        s_axi_bresp         = st_ff.bresp;
        s_axi_arready       = ~st_ff.rvalid;
        s_axi_rvalid        = st_ff.rvalid;
        s_axi_rdata         = st_ff.rdata;
        s_axi_rresp         = st_ff.rresp;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence link_edge_s;
        st_ff.pin_s2[`DPO_PIN_LCLK] && !st_ff.link_prev && awake;
    endsequence

    sequence clk_rise_s;
        !st_ff.rclk ##1 st_ff.rclk;
    endsequence

    a_clock_from_link: assert property (
        clk_rise_s |-> $past(link_edge) && st_ff.bitcnt == 5'h00)
        else $error("recovered clock rose without a word boundary");
    a_unlock_release: assert property (
        !lock_out |-> !recovered_data_oe && !recovered_clock_oe)
        else $error("outputs driven while unlocked");
    a_edge_update: assert property (
        $changed(st_ff.dout) |->
            ($past(st_ff.pin_s2[`DPO_PIN_EDGE]) ? $rose(st_ff.rclk)
                                                : $fell(st_ff.rclk)))
        else $error("data changed on the wrong clock edge");
    a_oe_release: assert property (
        !st_ff.pin_s2[`DPO_PIN_OE] |-> !recovered_clock_oe
            && !recovered_data_oe)
        else $error("outputs driven with enable low");
    a_standby_off: assert property (
        !awake |-> !lock_oe ##1 (st_ff.lock == DPO_HUNT) && !st_ff.rclk)
        else $error("standby did not stop recovery");
    a_lane_shift: assert property (
        link_edge_s |=> st_ff.idle == 8'h00
            && st_ff.shift[1:0] == $past(st_ff.pin_s2[2:1]))
        else $error("link edge not taken");
    a_drive_cond: assert property (
        recovered_data_oe |-> awake && lock_out
            && st_ff.pin_s2[`DPO_PIN_OE])
        else $error("data driven outside lock and enable");

endmodule

// *** logic/dpo_defines.svh ***
`ifndef DPO_DEFINES_SVH
`define DPO_DEFINES_SVH

// register byte offsets
`define DPO_OFF_CTRL     5'h00
`define DPO_OFF_STATUS   5'h04
`define DPO_OFF_IRQ_STAT 5'h08
`define DPO_OFF_IRQ_EN   5'h0c
`define DPO_OFF_IRQ_CLR  5'h10
`define DPO_OFF_WORD     5'h14

// field positions
`define DPO_CTRL_QUAD    0
`define DPO_IRQ_LOCKED   0
`define DPO_IRQ_UNLOCKED 1
`define DPO_IRQ_WORD     2

// reset values
`define DPO_CTRL_RST     1'b1
`define DPO_IRQ_EN_RST   3'h0

// pin index within the synchroniser vector
`define DPO_PIN_LCLK     0
`define DPO_PIN_STBY     5
`define DPO_PIN_OE       6
`define DPO_PIN_EDGE     7
`define DPO_PIN_STRAP    8

// timing
`define DPO_CLK_PERIOD_NS 20
`define DPO_LINK_IDLE_NS  1000
`define DPO_LINK_IDLE_CYC (`DPO_LINK_IDLE_NS / `DPO_CLK_PERIOD_NS)
`define DPO_LOCK_WORDS    3'h4
`define DPO_BITS_QUAD     5'h08
`define DPO_BITS_DUAL     5'h10

`endif

// *** logic/dpo_pkg.sv ***
package dpo_pkg;

    // recovery loop state
    typedef enum logic [1:0] {
        DPO_HUNT   = 2'b00,
        DPO_LOCKED = 2'b01
    } dpo_lock_t;

    // whole state of the block
    typedef struct packed {
        logic [8:0]  pin_s1;     // first sync stage
        logic [8:0]  pin_s2;     // second sync stage
        logic        link_prev;  // last synced link clock level
        dpo_lock_t   lock;       // acquisition state
        logic [31:0] shift;      // lane shift register
        logic [4:0]  bitcnt;     // link edges into current word
        logic [2:0]  words;      // good words while hunting
        logic [7:0]  idle;       // cycles since last link edge
        logic [31:0] hold;       // last complete word
        logic [31:0] dout;       // parallel output word
        logic        rclk;       // recovered parallel clock
        logic        quad;       // four lanes when set
        logic [2:0]  irq_stat;   // sticky events
        logic [2:0]  irq_en;     // event enables
        logic        aw_got;     // write address held
        logic [4:0]  awaddr;     // held write address
        logic        w_got;      // write data held
        logic [31:0] wdata;      // held write data
        logic        bvalid;     // write response pending
        logic [1:0]  bresp;      // write response code
        logic        rvalid;     // read data pending
        logic [31:0] rdata;      // read data
        logic [1:0]  rresp;      // read response code
    } dpo_state_t;

endpackage

// *** testbench/dpo_ser_model.sv ***
`timescale 1ns/1ns

// far-end serializer: embedded link clock plus up to four lanes
module dpo_ser_model (
    clk,      // bench clock that paces the link
    link_clk, // link clock, still between frames
    lanes     // serial lanes 0..3
);
    input  wire        clk;      // bench clock in
    output logic       link_clk; // link clock out
    output logic [3:0] lanes;    // lane bits out

    initial begin
        link_clk = 1'b0;
        lanes    = 4'h0;
    end

    // one word, first bits first; four clocks a half period, 80 ns
    // lanes move with the fall so they stand half a period each side
    task automatic send(input logic [31:0] w, input logic quad);
        logic [31:0] s;
        s = w;
        @(posedge clk);
        repeat (quad ? 8 : 16) begin
            // unused lanes toggle so no stale value looks valid
            lanes <= quad ? s[31:28] : {~lanes[3:2], s[31:30]};
            s = quad ? (s << 4) : (s << 2);
            repeat (4) @(posedge clk);
            link_clk <= 1'b1;
            repeat (4) @(posedge clk);
            link_clk <= 1'b0;
        end
        lanes <= ~lanes; // released lines show the inverse
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`include "dpo_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    n_mismatch++; $display("ERROR %0t got %h want %h", $time, a, b); end end

module tb_top
    import dpo_pkg::*;
;
    logic        clk = 1'b0;   // system clock
    logic        rst = 1'b1;   // sync reset
    logic        link_clk;     // from far end
    logic [3:0]  lanes;        // from far end
    logic        stby_n = 1'b1; // awake
    logic        oe = 1'b1;    // output enable pin
    logic        sel = 1'b1;   // edge select pin
    logic        strap = 1'b0; // held low by the board
    logic [31:0] dout;         // parallel word
    logic        d_oe, c_oe, rclk, lock, l_oe, irq; // pin outputs
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00; // bus addresses
    logic [31:0] wdata = 32'h0; // write data
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0; // write
    logic        arvalid = 1'b0, rready = 1'b0; // read requests
    logic        awready, wready, bvalid, arready, rvalid; // answers
    logic [1:0]  bresp, rresp; // response codes
    logic [31:0] rdata;        // read data
    logic [31:0] seed = 32'h45; // lfsr state
    logic [31:0] d, last, prev; // read word and sent words
    logic [1:0]  r;            // response
    int          n_mismatch = 0; // failed compares
    int          total_checks = 0; // all compares

    always #10 clk = ~clk; // 50 MHz

    dpo_top dut (.clk(clk), .rst(rst), .link_clk(link_clk),
        .serial_lane_in(lanes), .standby_n(stby_n), .output_enable(oe),
        .output_edge_select(sel), .reserved_strap(strap),
        .recovered_data_out(dout), .recovered_data_oe(d_oe),
        .recovered_clock_out(rclk), .recovered_clock_oe(c_oe),
        .lock_out(lock), .lock_oe(l_oe), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    dpo_ser_model ser (.clk(clk), .link_clk(link_clk), .lanes(lanes));

    // maximal-length style shift register for random words
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // rising select shows the newest word, falling the one before
    function automatic logic [31:0] exp_out(input logic s,
                                            input logic [31:0] l, p);
        return s ? l : p;
    endfunction

    // ready is sampled mid-cycle; inputs only move at rising edges
    task automatic wr(input logic [4:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
        logic ta, tw;
        @(posedge clk);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do begin
            @(negedge clk);
            ta = bvalid;
            resp = bresp;
            @(posedge clk);
        end while (!ta);
        bready <= 1'b0;
    endtask

    // read: hold arvalid until taken, rready until rvalid
    task automatic rd(input logic [4:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        logic t;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge clk);
            t = arready;
            @(posedge clk);
        end while (!t);
        arvalid <= 1'b0;
        do begin
            @(negedge clk);
            t = rvalid;
            v = rdata;
            resp = rresp;
            @(posedge clk);
        end while (!t);
        rready <= 1'b0;
    endtask

    // wait, then stop mid-cycle where outputs are settled
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // five random words: lock comes on the fourth
    task automatic burst(input logic q);
        repeat (5) begin
            seed = lfsr(seed);
            prev = last;
            last = seed;
            ser.send(seed, q);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog far beyond the expected 1500 cycles
    initial begin
        #200000;
        n_mismatch++;
        print_verdict;
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(`DPO_OFF_CTRL, d, r); `CHK(d[0], `DPO_CTRL_RST)
        rd(`DPO_OFF_IRQ_EN, d, r); `CHK(d[2:0], `DPO_IRQ_EN_RST)
        rd(5'h18, d, r); `CHK(r, 2'b10)
        wr(5'h1c, 32'h0, r); `CHK(r, 2'b10)
        `CHK({lock, d_oe, c_oe}, 3'b000)
        wr(`DPO_OFF_IRQ_EN, 32'h1, r);
        // quad lanes, rising select, enabled
        burst(1'b1); waitc(6);
        `CHK({lock, d_oe, c_oe, l_oe}, 4'hf)
        `CHK(dout, exp_out(1'b1, last, prev))
        `CHK(rclk, 1'b1)
        `CHK(irq, 1'b1)
        rd(`DPO_OFF_STATUS, d, r); `CHK(d[2:0], 3'b011)
        // link goes quiet: lock drops, outputs released
        waitc(60); `CHK({lock, d_oe, c_oe}, 3'b000)
        `CHK(rclk, 1'b0)
        rd(`DPO_OFF_IRQ_STAT, d, r); `CHK(d[2:0], 3'h7)
        wr(`DPO_OFF_IRQ_CLR, 32'h7, r); waitc(2); `CHK(irq, 1'b0)
        rd(`DPO_OFF_IRQ_STAT, d, r); `CHK(d[2:0], 3'h0)
        // disabled outputs while the loop locks, falling select
        @(posedge clk); oe <= 1'b0; sel <= 1'b0;
        burst(1'b1); waitc(6);
        `CHK({lock, d_oe, c_oe}, 3'b100)
        `CHK(irq, 1'b1)
        @(posedge clk); oe <= 1'b1; waitc(4);
        `CHK({d_oe, c_oe}, 2'b11)
        `CHK(dout, exp_out(1'b0, last, prev))
        wr(`DPO_OFF_IRQ_EN, 32'h0, r); waitc(2); `CHK(irq, 1'b0)
        // dual lanes after the old lock has timed out
        waitc(60);
        @(posedge clk); sel <= 1'b1;
        wr(`DPO_OFF_CTRL, 32'h0, r);
        burst(1'b0); waitc(6);
        `CHK(dout, exp_out(1'b1, last, prev))
        rd(`DPO_OFF_WORD, d, r); `CHK(d, last)
        // standby releases the data, clock and lock outputs
        @(posedge clk); stby_n <= 1'b0; waitc(4);
        `CHK({l_oe, lock, d_oe, c_oe}, 4'h0)
        print_verdict;
    end
endmodule
